// File: sasp_serial_port.sv
// stereo adc audio serial port with i2c register file and sample fifo
// How it works
// - pll clocks withheld ten milliseconds after power-up
// - reset leaves every block powered down
// - power-down keeps all register contents
// - two-bit field picks converter clock source
// - dividers reach all standard sampling rates
// - left, right, stereo, dsp framing
// - msb first, word length 16 to 32
// - word and bit clock directions separate
// - word clock marks frame, pulse or square
// - word clock rate equals sample rate
// - divider sets master bit clock rate
// - slot mode off: one offset both channels, none in right framing
// - slot mode: second offset gaps second word, except in right framing
// - swap bit exchanges channel order
// - one of two processors at once
// - slave dsp uses word clock rise only
// - data valid on bit clock rising edges
// - slot mode ignores falling word clock edge, rising in stereo, neither in right framing

module sasp_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wrPtr_ff, rdPtr_ff, nxt_wrPtr, nxt_rdPtr;
    logic push, pop;

    always_comb
    begin
        push = inValid && inReady;
        pop = outValid && outReady;
        nxt_wrPtr = wrPtr_ff + (AW+1)'(push);
        nxt_rdPtr = rdPtr_ff + (AW+1)'(pop);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end
        else
        begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
        end
        if (push)
            mem_ff[wrPtr_ff[AW-1:0]] <= inData;
    end

    assign inReady = (wrPtr_ff - rdPtr_ff) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_ff != rdPtr_ff;
    assign outData = mem_ff[rdPtr_ff[AW-1:0]];
endmodule : sasp_fifo

module sasp_serial_port #(
    parameter logic [6:0] DEV_ADDR = 7'h2a,
    parameter int PLL_SETTLE_CYCLES = sasp_pkg::PLL_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    input wire logic bclkIn,
    output logic bclkOut,
    output logic bclkOeN,
    input wire logic wclkIn,
    output logic wclkOut,
    output logic wclkOeN,
    output logic doutOut,
    output logic doutOeN,
    input wire logic sampleValid,
    output logic sampleReady,
    input wire sasp_pkg::sasp_sample_t sampleData,
    output logic [1:0] converterClockSource,
    output logic converterClocksReady,
    output logic adcPowered,
    output logic processorSelect
);
    import sasp_pkg::*;
    // DEV_ADDR default is arbitrary

    // ----------------------------------------
    // pin synchronisers: scl, sda, bclk, wclk
    // ----------------------------------------
    logic [3:0] sync1_ff, sync2_ff, pinD_ff;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1_ff <= 4'hc;
            sync2_ff <= 4'hc;
            pinD_ff <= 4'hc;
        end
        else
        begin
            sync1_ff <= {sclIn, sdaIn, bclkIn, wclkIn};
            sync2_ff <= sync1_ff;
            pinD_ff <= sync2_ff;
        end
    end

    // ----------------------------------------
    // i2c register slave
    // ----------------------------------------
    sasp_i2c_t i2c_ff, nxtI;
    sasp_cfg_t cfg_ff, nxtCfg;
    logic sclRise, sclFall, startSeen, stopSeen, wrStrobe, fifoValid, clocksReady;
    logic [7:0] status;

    function automatic sasp_cfg_t regWrite(input sasp_cfg_t c, input logic [7:0] a,
                                           input logic [7:0] d);
        sasp_cfg_t r;
        r = c;
        case (a)
            REG_CLK_SRC: r.clkSrc = d;
            REG_FORMAT: r.format = d;
            REG_OFFSET1: r.offset1 = d;
            REG_BCLK_DIV: r.bclkDiv = d;
            REG_OFFSET2: r.offset2 = d;
            REG_CHAN_ARR: r.chanArr = d;
            default: r = c;
        endcase
        return r;
    endfunction : regWrite

    function automatic logic [7:0] regRead(input sasp_cfg_t c, input logic [7:0] a,
                                           input logic [7:0] s);
        case (a)
            REG_CLK_SRC: return c.clkSrc;
            REG_FORMAT: return c.format;
            REG_OFFSET1: return c.offset1;
            REG_BCLK_DIV: return c.bclkDiv;
            REG_OFFSET2: return c.offset2;
            REG_CHAN_ARR: return c.chanArr;
            REG_STATUS: return s;
            default: return 8'h00;
        endcase
    endfunction : regRead

    assign sclRise = sync2_ff[3] & ~pinD_ff[3];
    assign sclFall = ~sync2_ff[3] & pinD_ff[3];
    assign startSeen = sync2_ff[3] & pinD_ff[3] & ~sync2_ff[2] & pinD_ff[2];
    assign stopSeen = sync2_ff[3] & pinD_ff[3] & sync2_ff[2] & ~pinD_ff[2];
    assign wrStrobe = (i2c_ff.st == I_RECV) && sclFall && (i2c_ff.cnt == 4'h8)
        && (i2c_ff.phase == PH_DATA) && !startSeen && !stopSeen;
    always_comb
    begin
        status = 8'h00;
        status[STAT_READY_BIT] = clocksReady;
        status[STAT_EMPTY_BIT] = ~fifoValid;
    end

    always_comb
    begin
        nxtI = i2c_ff;
        nxtCfg = cfg_ff;
        if (stopSeen)
        begin
            nxtI.st = I_IDLE;
            nxtI.drv = 1'b0;
        end
        else if (startSeen)
        begin
            nxtI.st = I_RECV;
            nxtI.cnt = 4'h0;
            nxtI.phase = PH_ADDR;
            nxtI.drv = 1'b0;
        end
        else
        begin
            case (i2c_ff.st)
                I_RECV:
                    if (sclRise)
                    begin
                        nxtI.sh = {i2c_ff.sh[6:0], sync2_ff[2]};
                        nxtI.cnt = i2c_ff.cnt + 4'h1;
                    end
                    else if (sclFall && i2c_ff.cnt == 4'h8)
                    begin
                        nxtI.st = I_ACK;
                        nxtI.drv = 1'b1;
                        if (i2c_ff.phase == PH_ADDR)
                        begin
                            nxtI.rd = i2c_ff.sh[0];
                            if (i2c_ff.sh[7:1] != DEV_ADDR)
                            begin
                                nxtI.st = I_IDLE;
                                nxtI.drv = 1'b0;
                            end
                        end
                        else if (i2c_ff.phase == PH_REG)
                            nxtI.ptr = i2c_ff.sh;
                        else
                        begin
                            nxtCfg = regWrite(cfg_ff, i2c_ff.ptr, i2c_ff.sh);
                            nxtI.ptr = i2c_ff.ptr + 8'h01;
                        end
                    end
                I_ACK:
                    if (sclFall)
                    begin
                        nxtI.cnt = 4'h1;
                        nxtI.st = i2c_ff.rd ? I_SEND : I_RECV;
                        nxtI.sh = regRead(cfg_ff, i2c_ff.ptr, status);
                        nxtI.drv = i2c_ff.rd & ~nxtI.sh[7];
                        if (!i2c_ff.rd)
                        begin
                            nxtI.cnt = 4'h0;
                            nxtI.phase = (i2c_ff.phase == PH_ADDR) ? PH_REG : PH_DATA;
                        end
                    end
                I_SEND:
                    if (sclFall && i2c_ff.cnt == 4'h8)
                    begin
                        nxtI.st = I_RACK;
                        nxtI.drv = 1'b0;
                        nxtI.ptr = i2c_ff.ptr + 8'h01;
                    end
                    else if (sclFall)
                    begin
                        nxtI.sh = {i2c_ff.sh[6:0], 1'b0};
                        nxtI.drv = ~i2c_ff.sh[6];
                        nxtI.cnt = i2c_ff.cnt + 4'h1;
                    end
                I_RACK:
                    if (sclRise)
                        nxtI.st = sync2_ff[2] ? I_IDLE : I_ACK;
                default: nxtI.st = I_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            i2c_ff <= '{st: I_IDLE, default: '0};
            cfg_ff <= {6{CFG_RESET}};
        end
        else
        begin
            i2c_ff <= nxtI;
            cfg_ff <= nxtCfg;
        end
    end

    // ----------------------------------------
    // pll settle and clock generators
    // ----------------------------------------
    logic [31:0] pllCnt_ff, nxt_pllCnt;
    logic pllDone, run, bMaster, wMaster, bRise, bFall, bclkUse, wNow;
    logic [7:0] divN;
    sasp_clkgen_t cg_ff, nxtCg;
    sasp_frame_t fr_ff, nxtFr;

    assign pllDone = pllCnt_ff == 32'(PLL_SETTLE_CYCLES);
    assign clocksReady = (cfg_ff.clkSrc[1:0] != CSRC_PLL) | pllDone;
    assign run = cfg_ff.clkSrc[ADC_PWR_BIT] & clocksReady;
    assign bMaster = cfg_ff.format[BCLK_MST_BIT];
    assign wMaster = cfg_ff.format[WCLK_MST_BIT];
    assign divN = (cfg_ff.bclkDiv[6:0] == 7'h00) ? DIV_ZERO_MEANS : {1'b0, cfg_ff.bclkDiv[6:0]};
    assign bclkUse = bMaster ? cg_ff.bclkGen : sync2_ff[1];
    assign wNow = wMaster ? cg_ff.wclkGen : sync2_ff[0];
    assign bRise = bclkUse & ~fr_ff.bPrev;
    assign bFall = ~bclkUse & fr_ff.bPrev;

    always_comb
    begin
        nxt_pllCnt = pllCnt_ff;
        if (!cfg_ff.clkSrc[PLL_PWR_BIT])
            nxt_pllCnt = 32'h0;
        else if (!pllDone)
            nxt_pllCnt = pllCnt_ff + 32'h1;
        nxtCg = cg_ff;
        if (run && bMaster)
        begin
            nxtCg.divCnt = cg_ff.divCnt + 8'h01;
            if (cg_ff.divCnt >= divN - 8'h01)
            begin
                nxtCg.divCnt = 8'h00;
                nxtCg.bclkGen = ~cg_ff.bclkGen;
            end
        end
        else
        begin
            nxtCg.divCnt = 8'h00;
            nxtCg.bclkGen = 1'b0;
        end
        if (!(run && wMaster))
        begin
            nxtCg.bitCnt = 8'h00;
            nxtCg.wclkGen = 1'b0;
        end
        else if (bFall)
        begin
            nxtCg.bitCnt = (cg_ff.bitCnt == MASTER_FRAME_BITS - 8'h01) ? 8'h00
                : cg_ff.bitCnt + 8'h01;
            nxtCg.wclkGen = cfg_ff.format[WCLK_PULSE_BIT] ? (nxtCg.bitCnt == 8'h00)
                : (nxtCg.bitCnt < MASTER_HALF_BITS);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pllCnt_ff <= 32'h0;
            cg_ff <= '0;
        end
        else
        begin
            pllCnt_ff <= nxt_pllCnt;
            cg_ff <= nxtCg;
        end
    end

    // ----------------------------------------
    // frame engine and sample fifo
    // ----------------------------------------
    sasp_sample_t fifoData;
    logic [1:0] fmt;
    logic isStereo, isRight, slot, useOpp, wRise, wFall, frameEdge, oppEdge, popWord;
    logic [8:0] wl, off, aStart, bStart, bRef;
    logic [1:0] hitA, hitB;
    logic [31:0] firstWord, secondWord;

    function automatic logic [1:0] slotBit(input logic [31:0] w, input logic [8:0] p,
                                           input logic [8:0] s, input logic [8:0] n);
        logic [8:0] d;
        d = p - s;
        return {d < n, w[5'(n - 9'h001 - d)]};
    endfunction : slotBit

    assign fmt = cfg_ff.format[7:6];
    assign isStereo = fmt == FMT_STEREO;
    assign isRight = fmt == FMT_RIGHT;
    assign slot = cfg_ff.chanArr[SLOT_BIT];
    assign useOpp = (fmt != FMT_DSP) && (!slot || isRight);
    assign wRise = wNow & ~fr_ff.wSamp;
    assign wFall = ~wNow & fr_ff.wSamp;
    assign frameEdge = bRise & (isStereo ? wFall : wRise);
    assign oppEdge = bRise & useOpp & (isStereo ? wRise : wFall);
    assign popWord = frameEdge & run;
    assign wl = sasp_word_bits(cfg_ff.format[5:4]);
    assign off = {1'b0, cfg_ff.offset1} + {8'h00, isStereo};
    assign aStart = isRight ? fr_ff.half - wl - 9'h001 : off;
    assign bStart = isRight ? fr_ff.len - fr_ff.half - wl - 9'h001
        : useOpp ? off : off + wl + (slot ? {1'b0, cfg_ff.offset2} : 9'h000);
    assign bRef = useOpp ? fr_ff.pos2 : fr_ff.pos;
    assign firstWord = cfg_ff.chanArr[SWAP_BIT] ? fr_ff.word.right : fr_ff.word.left;
    assign secondWord = cfg_ff.chanArr[SWAP_BIT] ? fr_ff.word.left : fr_ff.word.right;
    assign hitA = slotBit(firstWord, fr_ff.pos, aStart, wl);
    assign hitB = slotBit(secondWord, bRef, bStart, wl);

    always_comb
    begin
        nxtFr = fr_ff;
        nxtFr.bPrev = bclkUse;
        if (bRise)
        begin
            nxtFr.wSamp = wNow;
            nxtFr.pos = frameEdge ? 9'h000 : fr_ff.pos + {8'h00, fr_ff.pos != 9'h1ff};
            nxtFr.pos2 = oppEdge ? 9'h000 : fr_ff.pos2 + {8'h00, fr_ff.pos2 != 9'h1ff};
            if (frameEdge)
            begin
                nxtFr.len = fr_ff.pos + 9'h001;
                nxtFr.word = fifoValid ? fifoData : '0;
            end
            if (oppEdge)
                nxtFr.half = fr_ff.pos + 9'h001;
        end
        if (bFall)
        begin
            // data changes on the falling edge so the rising edge samples it clean
            nxtFr.dout = hitA[1] ? hitA[0] : hitB[1] & hitB[0];
            nxtFr.en = hitA[1] | hitB[1] | ~cfg_ff.format[TRI_END_BIT];
        end
        if (!run)
            nxtFr.en = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            fr_ff <= '0;
        else
            fr_ff <= nxtFr;
    end

    sasp_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .inData(sampleData),
        .outValid(fifoValid),
        .outReady(popWord),
        .outData(fifoData)
    );

    // ----------------------------------------
    // pins and status outputs
    // ----------------------------------------
    assign sdaOut = 1'b0;
    assign sdaOeN = ~i2c_ff.drv;
    assign bclkOut = cg_ff.bclkGen;
    assign bclkOeN = ~(bMaster & run);
    assign wclkOut = cg_ff.wclkGen;
    assign wclkOeN = ~(wMaster & run);
    assign doutOut = fr_ff.dout;
    assign doutOeN = ~fr_ff.en;
    assign converterClockSource = cfg_ff.clkSrc[1:0];
    assign converterClocksReady = clocksReady;
    assign adcPowered = run;
    assign processorSelect = cfg_ff.chanArr[PROC_SEL_BIT];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    pll_wait_a: assert property (@(posedge clk) disable iff (rst)
        ($rose(cfg_ff.clkSrc[PLL_PWR_BIT]) && converterClockSource == CSRC_PLL)
        |-> !converterClocksReady) else $error("pll clocks released early");
    reset_down_a: assert property (@(posedge clk)
        rst |=> !adcPowered && bclkOeN && wclkOeN && doutOeN)
        else $error("block powered after reset");
    regs_kept_a: assert property (@(posedge clk) disable iff (rst)
        !wrStrobe |=> $stable(cfg_ff)) else $error("register changed without a write");
    src_ready_a: assert property (@(posedge clk) disable iff (rst)
        (converterClockSource != CSRC_PLL) |-> converterClocksReady)
        else $error("non pll source not ready");
    slave_pins_a: assert property (@(posedge clk) disable iff (rst)
        (!bMaster |-> bclkOeN) and (!wMaster |-> wclkOeN)) else $error("slave clock driven");
    bclk_div_a: assert property (@(posedge clk) disable iff (rst)
        (run && bMaster && $past(run && bMaster) && $changed(cg_ff.bclkGen))
        |-> $past(cg_ff.divCnt) >= $past(divN) - 8'h01) else $error("bit clock divider off");
    dsp_rise_a: assert property (@(posedge clk) disable iff (rst)
        (bRise && fmt == FMT_DSP && wFall && fr_ff.pos != 9'h1ff)
        |=> fr_ff.pos == $past(fr_ff.pos) + 9'h001) else $error("dsp used falling edge");
    swap_load_a: assert property (@(posedge clk) disable iff (rst)
        (popWord && fifoValid && cfg_ff.chanArr[SWAP_BIT])
        |=> firstWord == $past(fifoData.right)) else $error("swap order wrong");
endmodule : sasp_serial_port

// File: sasp_pkg.sv
// package: register map, fields, states and timing of the stereo adc serial port
package sasp_pkg;
    // ----------------------------------------
    // register offsets and reset value
    // ----------------------------------------
    localparam logic [7:0] REG_CLK_SRC = 8'h04;
    localparam logic [7:0] REG_FORMAT = 8'h1b;
    localparam logic [7:0] REG_OFFSET1 = 8'h1c;
    localparam logic [7:0] REG_BCLK_DIV = 8'h1e;
    localparam logic [7:0] REG_OFFSET2 = 8'h25;
    localparam logic [7:0] REG_CHAN_ARR = 8'h26;
    localparam logic [7:0] REG_STATUS = 8'h27;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // ----------------------------------------
    // field positions and codes
    // ----------------------------------------
    localparam int PLL_PWR_BIT = 7;
    localparam int ADC_PWR_BIT = 6;
    localparam int BCLK_MST_BIT = 3;
    localparam int WCLK_MST_BIT = 2;
    localparam int WCLK_PULSE_BIT = 1;
    localparam int TRI_END_BIT = 0;
    localparam int SLOT_BIT = 0;
    localparam int SWAP_BIT = 4;
    localparam int PROC_SEL_BIT = 5;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_EMPTY_BIT = 1;
    localparam logic [1:0] CSRC_MCLK = 2'h0;
    localparam logic [1:0] CSRC_BCLK = 2'h1;
    localparam logic [1:0] CSRC_PLL = 2'h3;
    localparam logic [1:0] FMT_STEREO = 2'h0;
    localparam logic [1:0] FMT_DSP = 2'h1;
    localparam logic [1:0] FMT_RIGHT = 2'h2;
    localparam logic [1:0] FMT_LEFT = 2'h3;
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_REG = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam logic [7:0] MASTER_FRAME_BITS = 8'h40;
    localparam logic [7:0] MASTER_HALF_BITS = 8'h20;
    localparam logic [7:0] DIV_ZERO_MEANS = 8'h80;
    localparam int CLK_HZ = 40_000_000;
    localparam int PLL_SETTLE_MS = 10;
    localparam int PLL_SETTLE_CYC = CLK_HZ / 1000 * PLL_SETTLE_MS;
    localparam int FIFO_DEPTH = 8;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [4:0] {
        I_IDLE = 5'h01,
        I_RECV = 5'h02,
        I_ACK = 5'h04,
        I_SEND = 5'h08,
        I_RACK = 5'h10
    } sasp_i2c_st_t;
    typedef struct packed {logic [31:0] left; logic [31:0] right;} sasp_sample_t;
    typedef struct packed {
        logic [7:0] clkSrc, format, offset1, bclkDiv, offset2, chanArr;
    } sasp_cfg_t;
    typedef struct packed {
        sasp_i2c_st_t st; logic [3:0] cnt; logic [7:0] sh; logic [1:0] phase;
        logic rd; logic [7:0] ptr; logic drv;
    } sasp_i2c_t;
    typedef struct packed {
        logic [7:0] divCnt; logic bclkGen; logic [7:0] bitCnt; logic wclkGen;
    } sasp_clkgen_t;
    typedef struct packed {
        logic bPrev; logic wSamp; logic [8:0] pos, pos2, half, len;
        sasp_sample_t word; logic dout, en;
    } sasp_frame_t;

    function automatic logic [8:0] sasp_word_bits(input logic [1:0] code);
        case (code)
            2'h0: return 9'h010;
            2'h1: return 9'h014;
            2'h2: return 9'h018;
            default: return 9'h020;
        endcase
    endfunction : sasp_word_bits
endpackage : sasp_pkg

// File: sasp_host_model.sv
// host-side serial audio model: drives bit and word clocks, captures data
module sasp_host_model #(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic run,
    input wire logic doutOut,
    input wire logic doutOeN,
    output logic bclk,
    output logic wclk,
    output logic [15:0] word1,
    output logic [15:0] word2,
    output int frames
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    int bitNo = 63;
    logic line;
    // a released data line reads as z, never as the last value
    assign line = doutOeN ? 1'bz : doutOut;
    initial
    begin
        bclk = 1'b0;
        wclk = 1'b0;
        frames = 0;
    end
    // clocks stand still while run is low
    always @(posedge clk)
    begin
        if (run && cnt == HALF - 1)
        begin
            bclk <= !bclk;
            if (bclk)
            begin
                bitNo <= (bitNo + 1) % 64;
                wclk <= ((bitNo + 1) % 64) < 32;
            end
            else if (bitNo >= 1 && bitNo <= 16)
                word1[16 - bitNo] <= line;
            else if (bitNo >= 33 && bitNo <= 48)
                word2[48 - bitNo] <= line;
            else if (bitNo == 49)
                frames <= frames + 1;
        end
        cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
    end
endmodule : sasp_host_model

// File: tb_top.sv
// testbench: register access, pll settling, fifo fill and serial frames
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sasp_pkg::*;
    logic clk = 0, rst = 1, scl = 1, sdaM = 1, run = 0, sampleValid = 0, swap = 0;
    sasp_sample_t sampleData = '0;
    logic sdaOeN, bclk, wclk, bclkOeN, doutOut, doutOeN, sampleReady, ready, powered;
    logic wclkOeN, procSel, bOut, wOut, bSeen, sdaLow;
    logic [1:0] src;
    logic [15:0] word1, word2;
    logic [7:0] rdv;
    int frames, failCount = 0, comparisons = 0, cyc = 0, edges = 0, highCount = 0;
    sasp_sample_t q[$];
    wire logic sda = sdaM & (sdaOeN | sdaLow);
    always #12.5 clk = ~clk;
    sasp_serial_port #(.PLL_SETTLE_CYCLES(200)) dut (
        .clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaLow), .sdaOeN(sdaOeN),
        .bclkIn(bclk), .bclkOut(bOut), .bclkOeN(bclkOeN), .wclkIn(wclk), .wclkOut(wOut),
        .wclkOeN(wclkOeN), .doutOut(doutOut), .doutOeN(doutOeN), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .sampleData(sampleData), .converterClockSource(src),
        .converterClocksReady(ready), .adcPowered(powered), .processorSelect(procSel));
    sasp_host_model #(.HALF(8)) host (.clk(clk), .run(run), .doutOut(doutOut),
        .doutOeN(doutOeN), .bclk(bclk), .wclk(wclk), .word1(word1), .word2(word2),
        .frames(frames));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            failCount++;
        end
    endtask : check
    task finish_test();
        if (failCount == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task tick(int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task bitx(logic b, output logic r);
        tick(1);
        sdaM = b;
        tick(6);
        scl = 1;
        tick(6);
        r = sda;
        scl = 0;
    endtask : bitx
    task start();
        sdaM = 1;
        tick(6);
        scl = 1;
        tick(6);
        sdaM = 0;
        tick(6);
        scl = 0;
    endtask : start
    task stop();
        tick(1);
        sdaM = 0;
        tick(6);
        scl = 1;
        tick(6);
        sdaM = 1;
        tick(6);
    endtask : stop
    task sendb(logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask : sendb
    task wr(logic [7:0] a, logic [7:0] d);
        logic k;
        start();
        sendb(8'h54, k);
        sendb(a, k);
        sendb(d, k);
        stop();
    endtask : wr
    task rd(logic [7:0] a, output logic [7:0] d);
        logic k;
        start();
        sendb(8'h54, k);
        sendb(a, k);
        start();
        sendb(8'h55, k);
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(1'b1, k);
        stop();
    endtask : rd
    task push(int n);
        for (int i = 0; i < n; i++)
        begin
            sampleValid = 1;
            sampleData = {$urandom, $urandom};
            q.push_back(sampleData);
            @(posedge clk);
            tick(1);
        end
        sampleValid = 0;
    endtask : push
    // an empty queue stands for the zero words sent when nothing was buffered
    task frame(int n);
        int f;
        sasp_sample_t e;
        repeat (n)
        begin
            f = frames;
            while (frames == f)
                tick(1);
            e = q.size() > 0 ? q.pop_front() : '0;
            check("first word", word1, swap ? e.right[15:0] : e.left[15:0]);
            check("second word", word2, swap ? e.left[15:0] : e.right[15:0]);
        end
    endtask : frame
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            failCount++;
            finish_test();
        end
    end
    initial
    begin
        void'($urandom(81998));
        tick(6);
        rst = 0;
        tick(3);
        check("port powered", powered, 0);
        check("dout enable", doutOeN, 1);
        rd(REG_FORMAT, rdv);
        check("format reset", rdv, CFG_RESET);
        start();
        sendb(8'h56, rdv[0]);
        check("foreign address ack", rdv[0], 0);
        stop();
        wr(REG_FORMAT, 8'hc1);
        wr(REG_CLK_SRC, 8'h83);
        check("clock source", src, CSRC_PLL);
        check("clocks early", ready, 0);
        tick(120);
        check("clocks held", ready, 0);
        tick(150);
        check("clocks settled", ready, 1);
        wr(REG_CLK_SRC, 8'h00);
        rd(REG_FORMAT, rdv);
        check("format kept", rdv, 8'hc1);
        rd(8'h30, rdv);
        check("unmapped read", rdv, 0);
        push(8);
        check("fifo full", sampleReady, 0);
        wr(REG_CLK_SRC, 8'h40);
        check("port running", powered, 1);
        check("slave bit clock", bclkOeN, 1);
        check("slave word clock", wclkOeN, 1);
        run = 1;
        frame(10);
        check("fifo drained", sampleReady, 1);
        run = 0;
        swap = 1;
        wr(REG_CHAN_ARR, 8'h30);
        check("processor select", procSel, 1);
        push(3);
        run = 1;
        frame(4);
        run = 0;
        wr(REG_BCLK_DIV, 8'h04);
        wr(REG_FORMAT, 8'hcd);
        check("master bit clock", bclkOeN, 0);
        check("master word clock", wclkOeN, 0);
        tick(20);
        bSeen = bOut;
        repeat (1024)
        begin
            tick(1);
            edges += int'(bOut != bSeen);
            bSeen = bOut;
            highCount += int'(wOut);
        end
        check("bit clock edges", edges, 1024 / 4);
        check("word clock high", highCount, 16 * MASTER_HALF_BITS);
        finish_test();
    end
endmodule : tb_top
